// ### rtl/tcsf_top.sv
// Torque command source selection, scaling and smoothing.
// Assumes select inputs and analog reference already synchronous to i_clk.
`timescale 1ns/100ps
module tcsf_top #(
  parameter int P_TICK_CYCLES = tcsf_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  // Register port
  input  wire logic [tcsf_pkg::AW-1:0]   i_addr,
  input  wire logic [tcsf_pkg::DW-1:0]   i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [tcsf_pkg::DW-1:0]   o_rdata,
  // Controller inputs
  input  wire logic                      i_torque_sel_low,
  input  wire logic                      i_torque_sel_high,
  input  wire logic signed [tcsf_pkg::DW-1:0] i_analog_mv,
  // Command outputs
  output logic signed [tcsf_pkg::DW-1:0] o_torque_cmd,
  output logic signed [tcsf_pkg::DW-1:0] o_torque_limit,
  output logic                           o_tick,
  // Resonance settings to the speed loop, fixed current-loop gain
  output logic      [tcsf_pkg::DW-1:0]   o_notch_center_freq,
  output logic      [tcsf_pkg::DW-1:0]   o_notch_attenuation,
  output logic                           o_notch_enable,
  output logic      [tcsf_pkg::DW-1:0]   o_current_gain
);
  import tcsf_pkg::*;

  localparam int ACCW = 36;

  logic [DW-1:0]        ctrl_mode_reg;
  logic [DW-1:0]        smooth_reg;
  logic [DW-1:0]        full_scale_reg;
  logic [DW-1:0]        notch_freq_reg;
  logic [DW-1:0]        notch_atten_reg;
  logic [DW-1:0]        res_lp_reg;
  logic [DW-1:0]        preset_reg [NUM_PRESETS];
  logic [DW-1:0]        rdata_reg;
  logic [31:0]          tick_cnt_reg;
  logic                 tick;
  logic [1:0]           sel;
  logic [1:0]           sel_prev_reg;
  logic                 sel_seen_reg;
  logic signed [DW-1:0] preset_hold_reg;
  logic signed [DW-1:0] sel_cmd_reg;
  logic signed [DW-1:0] limit_reg;
  logic signed [DW-1:0] cmd_reg;
  logic signed [ACCW-1:0] smooth_acc_reg;
  logic signed [ACCW-1:0] res_acc_reg;
  tcsf_src_t            src;
  logic [1:0]           mode;
  logic                 torque_mode;
  logic signed [DW-1:0] ain_clamped;
  logic signed [31:0]   ain_product;
  logic signed [DW-1:0] ain_cmd;
  logic signed [DW-1:0] sel_cmd_next;
  logic signed [ACCW-1:0] smooth_acc_next;
  logic signed [ACCW-1:0] res_acc_next;
  logic signed [DW-1:0] smooth_out;

  assign mode        = ctrl_mode_reg[1:0];
  assign torque_mode = (mode == MODE_TORQUE) || (mode == MODE_ZERO_TQ);
  // Inputs are active high: contact closed reads 1.
  assign sel         = {i_torque_sel_high, i_torque_sel_low};

  // Writes outside the legal range are dropped, old value is kept.
  function automatic logic in_range(input logic [DW-1:0] v,
                                    input logic [DW-1:0] lo,
                                    input logic [DW-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_mode_reg   <= RST_CTRL_MODE;
      smooth_reg      <= RST_SMOOTH;
      full_scale_reg  <= RST_FULL_SCALE;
      notch_freq_reg  <= RST_NOTCH_FREQ;
      notch_atten_reg <= RST_NOTCH_ATTEN;
      res_lp_reg      <= RST_RES_LP;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        OFS_CTRL_MODE: begin
          ctrl_mode_reg <= {14'h0000, i_wdata[1:0]};
        end
        OFS_SMOOTH: begin
          if (in_range(i_wdata, 16'h0000, TC_MAX_MS))
            smooth_reg <= i_wdata;
        end
        OFS_FULL_SCALE: begin
          if (in_range(i_wdata, 16'h0000, FS_MAX_PCT))
            full_scale_reg <= i_wdata;
        end
        OFS_NOTCH_FREQ: begin
          if (in_range(i_wdata, NOTCH_MIN_HZ, NOTCH_MAX_HZ))
            notch_freq_reg <= i_wdata;
        end
        OFS_NOTCH_ATTEN: begin
          if (in_range(i_wdata, 16'h0000, ATTEN_MAX_DB))
            notch_atten_reg <= i_wdata;
        end
        OFS_RES_LP: begin
          if (in_range(i_wdata, 16'h0000, TC_MAX_MS))
            res_lp_reg <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRESETS; gi++) begin : g_preset
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          preset_reg[gi] <= RST_PRESET;
        end else if (i_ce && i_wr &&
                     i_addr == OFS_PRESET0 + AW'(gi) &&
                     $signed(i_wdata) >= PRESET_MIN &&
                     $signed(i_wdata) <= PRESET_MAX) begin
          preset_reg[gi] <= i_wdata;
        end
      end
    end
  endgenerate

  // Read data stand in the cycle after the strobe; unmapped reads 0.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (i_ce) begin
      rdata_reg <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          OFS_CTRL_MODE:   rdata_reg <= ctrl_mode_reg;
          OFS_SMOOTH:      rdata_reg <= smooth_reg;
          OFS_PRESET0:     rdata_reg <= preset_reg[0];
          OFS_PRESET0 + 12'h001: rdata_reg <= preset_reg[1];
          OFS_PRESET0 + 12'h002: rdata_reg <= preset_reg[2];
          OFS_FULL_SCALE:  rdata_reg <= full_scale_reg;
          OFS_NOTCH_FREQ:  rdata_reg <= notch_freq_reg;
          OFS_NOTCH_ATTEN: rdata_reg <= notch_atten_reg;
          OFS_RES_LP:      rdata_reg <= res_lp_reg;
          OFS_STAT_CMD:    rdata_reg <= cmd_reg;
          OFS_STAT_GAIN:   rdata_reg <= CURRENT_GAIN;
          OFS_STAT_FLAGS:  rdata_reg <= {11'h000, o_notch_enable,
                                         torque_mode, sel_seen_reg, sel};
          default:         rdata_reg <= 16'h0000;
        endcase
      end
    end
  end
  assign o_rdata = rdata_reg;

  // Control period strobe.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      if (tick)
        tick_cnt_reg <= 32'h0000_0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = i_ce && (tick_cnt_reg == 32'(P_TICK_CYCLES - 1));

  // Analog scaling: mV times percent over 1000 gives tenths of percent.
  always_comb begin
    if (i_analog_mv > AIN_MAX_MV)
      ain_clamped = AIN_MAX_MV;
    else if (i_analog_mv < AIN_MIN_MV)
      ain_clamped = AIN_MIN_MV;
    else
      ain_clamped = i_analog_mv;
    ain_product = 32'(ain_clamped) * 32'($signed({1'b0, full_scale_reg}));
    ain_cmd     = DW'(ain_product / SCALE_DIV);
  end

  // Position and speed modes have no zero-torque variant.
  always_comb begin
    if (sel != 2'b00)
      src = SRC_PRESET;
    else if (mode == MODE_ZERO_TQ)
      src = SRC_ZERO;
    else
      src = SRC_ANALOG;
    case (src)
      SRC_ANALOG: sel_cmd_next = ain_cmd;
      SRC_ZERO:   sel_cmd_next = 16'sh0000;
      SRC_PRESET: sel_cmd_next = DW'(preset_hold_reg * PCT_TO_CMD);
      default:    sel_cmd_next = 16'sh0000;
    endcase
  end

  // A preset is captured only when the select code changes or on the first tick after reset, so editing
  // the preset register alone does not move the motor.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sel_prev_reg    <= 2'b00;
      sel_seen_reg    <= 1'b0;
      preset_hold_reg <= 16'sh0000;
    end else if (tick) begin
      sel_prev_reg <= sel;
      sel_seen_reg <= 1'b1;
      if ((sel != sel_prev_reg || !sel_seen_reg) && sel != 2'b00)
        preset_hold_reg <= $signed(preset_reg[sel - 2'b01]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sel_cmd_reg <= 16'sh0000;
    end else if (tick) begin
      sel_cmd_reg <= sel_cmd_next;
    end
  end

  // First-order low-pass per period: acc += (x - acc) / (tau*k + 1).
  // The divide is costly; it is combinational and evaluated every cycle, but its result is loaded only on tick.
  always_comb begin
    smooth_acc_next = smooth_acc_reg +
      ((($signed({{(ACCW-DW){sel_cmd_reg[DW-1]}}, sel_cmd_reg}) <<< FRAC)
        - smooth_acc_reg) /
       $signed({20'h00000, 16'(smooth_reg * TICKS_PER_MS + 16'h0001)}));
    smooth_out = (smooth_reg == 16'h0000) ? sel_cmd_reg
               : DW'(smooth_acc_reg >>> FRAC);
    res_acc_next = res_acc_reg +
      ((($signed({{(ACCW-DW){smooth_out[DW-1]}}, smooth_out}) <<< FRAC)
        - res_acc_reg) /
       $signed({20'h00000, 16'(res_lp_reg * TICKS_PER_MS + 16'h0001)}));
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      smooth_acc_reg <= '0;
      res_acc_reg    <= '0;
    end else if (tick) begin
      smooth_acc_reg <= smooth_acc_next;
      res_acc_reg    <= res_acc_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmd_reg   <= 16'sh0000;
      limit_reg <= 16'sh0000;
    end else if (tick) begin
      if (torque_mode) begin
        cmd_reg   <= (res_lp_reg == 16'h0000) ? smooth_out
                   : DW'(res_acc_next >>> FRAC);
        limit_reg <= 16'sh0000;
      end else begin
        cmd_reg   <= 16'sh0000;
        limit_reg <= sel_cmd_reg;
      end
    end
  end

  assign o_torque_cmd        = cmd_reg;
  assign o_torque_limit      = limit_reg;
  assign o_tick              = tick;
  assign o_notch_center_freq = notch_freq_reg;
  assign o_notch_attenuation = notch_atten_reg;
  assign o_notch_enable      = (notch_atten_reg != 16'h0000);
  assign o_current_gain      = CURRENT_GAIN;

endmodule : tcsf_top

// ### rtl/tcsf_pkg.sv
// Constants, register map and types for the torque command select filter.
// Assumes a single 200 MHz clock and a plain strobe register port.
package tcsf_pkg;
  localparam int AW = 12;
  localparam int DW = 16;
  // Register offsets.
  localparam logic [AW-1:0] OFS_CTRL_MODE   = 12'h101;
  localparam logic [AW-1:0] OFS_SMOOTH      = 12'h107;
  localparam logic [AW-1:0] OFS_PRESET0     = 12'h10C;
  localparam logic [AW-1:0] OFS_FULL_SCALE  = 12'h129;
  localparam logic [AW-1:0] OFS_NOTCH_FREQ  = 12'h217;
  localparam logic [AW-1:0] OFS_NOTCH_ATTEN = 12'h218;
  localparam logic [AW-1:0] OFS_RES_LP      = 12'h219;
  localparam logic [AW-1:0] OFS_STAT_CMD    = 12'h300;
  localparam logic [AW-1:0] OFS_STAT_GAIN   = 12'h301;
  localparam logic [AW-1:0] OFS_STAT_FLAGS  = 12'h302;
  localparam int            NUM_PRESETS     = 3;
  // Reset values.
  localparam logic [DW-1:0] RST_CTRL_MODE   = 16'h0002;
  localparam logic [DW-1:0] RST_SMOOTH      = 16'h0000;
  localparam logic [DW-1:0] RST_PRESET      = 16'h0000;
  localparam logic [DW-1:0] RST_FULL_SCALE  = 16'h0064;
  localparam logic [DW-1:0] RST_NOTCH_FREQ  = 16'h03E8;
  localparam logic [DW-1:0] RST_NOTCH_ATTEN = 16'h0000;
  localparam logic [DW-1:0] RST_RES_LP      = 16'h0002;
  // Legal setting ranges.
  localparam logic [DW-1:0] TC_MAX_MS       = 16'h03E8;
  localparam logic [DW-1:0] NOTCH_MIN_HZ    = 16'h0032;
  localparam logic [DW-1:0] NOTCH_MAX_HZ    = 16'h03E8;
  localparam logic [DW-1:0] ATTEN_MAX_DB    = 16'h0020;
  localparam logic [DW-1:0] FS_MAX_PCT      = 16'h03E8;
  localparam logic signed [DW-1:0] PRESET_MAX = 16'sh012C;
  localparam logic signed [DW-1:0] PRESET_MIN = -16'sh012C;
  // Analog reference in millivolts, commands in tenths of percent.
  localparam logic signed [DW-1:0] AIN_MAX_MV = 16'sh2710;
  localparam logic signed [DW-1:0] AIN_MIN_MV = -16'sh2710;
  localparam logic signed [31:0]   SCALE_DIV  = 32'sh0000_03E8;
  localparam logic signed [DW-1:0] PCT_TO_CMD = 16'sh000A;
  // Fixed current-loop gain, arbitrary value.
  localparam logic [DW-1:0] CURRENT_GAIN    = 16'h0100;
  // Control mode field encoding.
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_SPEED    = 2'h1;
  localparam logic [1:0] MODE_TORQUE   = 2'h2;
  localparam logic [1:0] MODE_ZERO_TQ  = 2'h3;
  // Timing.
  localparam int CLK_PERIOD_NS  = 5;
  localparam int CTRL_PERIOD_NS = 50000;
  localparam int TICK_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NS_PER_MS      = 1000000;
  localparam logic [DW-1:0] TICKS_PER_MS =
    DW'(NS_PER_MS / CTRL_PERIOD_NS);
  localparam int FRAC = 16;
  typedef enum logic [2:0] {
    SRC_ANALOG = 3'b001,
    SRC_ZERO   = 3'b010,
    SRC_PRESET = 3'b100
  } tcsf_src_t;
endpackage : tcsf_pkg

// ### dv/tcsf_chk_sva.sv
// Port checker for the torque command select filter top level.
// Assumes it is bound onto tcsf_top with the same tick parameter.
`timescale 1ns/100ps
module tcsf_chk #(
  parameter int P_TICK_CYCLES = 10
) (
  // Clock, reset and enable
  input wire logic                           i_clk,
  input wire logic                           i_rst_n,
  input wire logic                           i_ce,
  // Register port
  input wire logic [tcsf_pkg::AW-1:0]        i_addr,
  input wire logic                           i_rd,
  input wire logic [tcsf_pkg::DW-1:0]        o_rdata,
  // Outputs
  input wire logic signed [tcsf_pkg::DW-1:0] o_torque_cmd,
  input wire logic signed [tcsf_pkg::DW-1:0] o_torque_limit,
  input wire logic                           o_tick,
  input wire logic [tcsf_pkg::DW-1:0]        o_notch_center_freq,
  input wire logic [tcsf_pkg::DW-1:0]        o_notch_attenuation,
  input wire logic                           o_notch_enable,
  input wire logic [tcsf_pkg::DW-1:0]        o_current_gain
);
  import tcsf_pkg::*;
  logic [31:0] tick_cnt_reg;
  // Counts enabled cycles since the last tick, so the spacing is checked
  // for any tick parameter without a long repetition.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || o_tick) tick_cnt_reg <= 32'h0;
    else if (i_ce) tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_tick_period: assert property (
    o_tick |-> tick_cnt_reg == P_TICK_CYCLES - 1)
    else $error("tick spacing wrong");
  a_cmd_hold: assert property (
    ($past(i_rst_n) && !$past(o_tick)) |->
      $stable(o_torque_cmd) && $stable(o_torque_limit))
    else $error("command moved between ticks");
  a_rdata_idle: assert property (
    ($past(i_ce) && !$past(i_rd)) |-> o_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_gain_read: assert property (
    ($past(i_rst_n) && $past(i_ce) && $past(i_rd) &&
     $past(i_addr) == 12'h301) |-> o_rdata == 16'h0100)
    else $error("current gain status wrong");
  a_gain_fixed: assert property (o_current_gain == 16'h0100)
    else $error("current gain changed");
  a_notch_enable: assert property (
    o_notch_enable == (o_notch_attenuation != 16'h0000))
    else $error("notch enable wrong");
  a_atten_range: assert property (o_notch_attenuation <= 16'h0020)
    else $error("attenuation out of range");
  a_freq_range: assert property (
    o_notch_center_freq >= 16'h0032 && o_notch_center_freq <= 16'h03E8)
    else $error("notch frequency out of range");
  a_cmd_limit_excl: assert property (
    o_torque_cmd == 16'sh0000 || o_torque_limit == 16'sh0000)
    else $error("command and limit both active");
endmodule : tcsf_chk

bind tcsf_top tcsf_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_chk (
  .i_clk, .i_rst_n, .i_ce, .i_addr, .i_rd, .o_rdata, .o_torque_cmd,
  .o_torque_limit, .o_tick, .o_notch_center_freq, .o_notch_attenuation,
  .o_notch_enable, .o_current_gain
);

// ### dv/tcsf_ctl_model.sv
// Motion controller model driving the select contacts and analog reference.
// Assumes the bench calls apply() and that inputs are clock-synchronous.
`timescale 1ns/100ps
module tcsf_ctl_model (
  // Clock
  input  wire logic                    i_clk,
  // Controller outputs
  output logic                         o_sel_low,
  output logic                         o_sel_high,
  output logic signed [tcsf_pkg::DW-1:0] o_analog_mv
);
  import tcsf_pkg::*;
  initial begin
    o_sel_low = 1'b0;
    o_sel_high = 1'b0;
    o_analog_mv = 16'sh0000;
  end
  // Contacts are levels; a closed contact reads as 1.
  task automatic apply(input logic [1:0] code,
                       input logic signed [DW-1:0] mv);
    @(posedge i_clk);
    o_sel_high <= code[1];
    o_sel_low <= code[0];
    o_analog_mv <= mv;
  endtask : apply
endmodule : tcsf_ctl_model

// ### dv/tb_top.sv
// Self-checking bench for the torque command select filter.
// Assumes the controller model drives the select and analog inputs.
`timescale 1ns/100ps
module tb_top;
  import tcsf_pkg::*;
  logic                 i_clk, i_rst_n, i_ce, i_wr, i_rd, sel_lo, sel_hi;
  logic                 o_tick, notch_en;
  logic [AW-1:0]        i_addr;
  logic [DW-1:0]        i_wdata, o_rdata, rd_val, nfreq, natt, gain;
  logic signed [DW-1:0] ain, cmd, lim;
  int                   n_fail, compares, cyc;
  localparam logic [AW-1:0] RA [6] = '{12'h101, 12'h107, 12'h129,
                                       12'h217, 12'h218, 12'h219};
  localparam logic [DW-1:0] RV [6] = '{16'h0002, 16'h0000, 16'h0064,
                                       16'h03E8, 16'h0000, 16'h0002};
  localparam logic [AW-1:0] TA [13] = '{12'h107, 12'h107, 12'h107,
    12'h219, 12'h219, 12'h217, 12'h217, 12'h218, 12'h218, 12'h129,
    12'h129, 12'h301, 12'h0FF};
  localparam logic [DW-1:0] TD [13] = '{16'h03E9, 16'h03E8, 16'h0000,
    16'h03E9, 16'h0000, 16'h0031, 16'h0032, 16'h0021, 16'h0020, 16'h03E9,
    16'h00C8, 16'h1234, 16'h1234};
  localparam logic [DW-1:0] TE [13] = '{16'h0000, 16'h03E8, 16'h0000,
    16'h0002, 16'h0000, 16'h03E8, 16'h0032, 16'h0000, 16'h0020, 16'h0064,
    16'h00C8, 16'h0100, 16'h0000};
  localparam logic [DW-1:0] PE [3] = '{16'h03E8, 16'hF448, 16'h0BB8};

  tcsf_top #(.P_TICK_CYCLES(10)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_torque_sel_low(sel_lo),
    .i_torque_sel_high(sel_hi), .i_analog_mv(ain), .o_torque_cmd(cmd),
    .o_torque_limit(lim), .o_tick(o_tick), .o_notch_center_freq(nfreq),
    .o_notch_attenuation(natt), .o_notch_enable(notch_en),
    .o_current_gain(gain));
  tcsf_ctl_model u_ctl (.i_clk(i_clk), .o_sel_low(sel_lo),
    .o_sel_high(sel_hi), .o_analog_mv(ain));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [DW-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // Three ticks cover the three-tick select-to-output latency of the preset path.
  task automatic run_cmd(input logic [1:0] code, input logic [DW-1:0] mv,
                         input logic [DW-1:0] ec, el);
    u_ctl.apply(code, mv);
    repeat (3) @(posedge i_clk iff o_tick === 1'b1);
    #1;
    chk("torque_cmd", ec, cmd);
    chk("torque_limit", el, lim);
  endtask : run_cmd

  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    i_ce = 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], rd_val);
      chk("reset_value", RV[i], rd_val);
    end
    for (int i = 0; i < 13; i++) begin
      wr(TA[i], TD[i]);
      rd(TA[i], rd_val);
      chk("reg_readback", TE[i], rd_val);
    end
    chk("notch_en", 16'h0001, {15'h0, notch_en});
    wr(OFS_NOTCH_ATTEN, 16'h0000);
    #1 chk("notch_en", 16'h0000, {15'h0, notch_en});
    // A frozen clock enable must swallow a write strobe.
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(OFS_SMOOTH, 16'h0005);
    i_ce <= 1'b1;
    rd(OFS_SMOOTH, rd_val);
    chk("ce_freeze", 16'h0000, rd_val);
    wr(OFS_CTRL_MODE, 16'h0002);
    run_cmd(2'b00, 16'h1388, 16'h03E8, 16'h0000);
    run_cmd(2'b00, 16'hD8F0, 16'hF830, 16'h0000);
    run_cmd(2'b00, 16'h4E20, 16'h07D0, 16'h0000);
    rd(OFS_STAT_CMD, rd_val);
    chk("status_cmd", 16'h07D0, rd_val);
    wr(OFS_CTRL_MODE, 16'h0003);
    run_cmd(2'b00, 16'h1388, 16'h0000, 16'h0000);
    wr(OFS_CTRL_MODE, 16'h0002);
    // Settle at zero so both filter stages start from an empty state.
    run_cmd(2'b00, 16'h0000, 16'h0000, 16'h0000);
    wr(OFS_SMOOTH, 16'h0001);
    run_cmd(2'b00, 16'h1388, 16'h002F, 16'h0000);
    wr(OFS_SMOOTH, 16'h0000);
    run_cmd(2'b00, 16'h0000, 16'h0000, 16'h0000);
    wr(OFS_RES_LP, 16'h0001);
    run_cmd(2'b00, 16'h1388, 16'h005C, 16'h0000);
    wr(OFS_RES_LP, 16'h0000);
    wr(12'h10C, 16'h0064);
    wr(12'h10D, 16'hFED4);
    wr(12'h10E, 16'h012C);
    wr(12'h10C, 16'h012D);
    rd(12'h10C, rd_val);
    chk("preset_range", 16'h0064, rd_val);
    for (int i = 0; i < 3; i++) begin
      run_cmd(2'(i + 1), 16'h1388, PE[i], 16'h0000);
    end
    wr(12'h10E, 16'h0032);
    run_cmd(2'b11, 16'h1388, 16'h0BB8, 16'h0000);
    run_cmd(2'b10, 16'h1388, 16'hF448, 16'h0000);
    run_cmd(2'b11, 16'h1388, 16'h01F4, 16'h0000);
    rd(OFS_STAT_FLAGS, rd_val);
    chk("status_flags", 16'h000F, rd_val);
    wr(OFS_CTRL_MODE, 16'h0001);
    run_cmd(2'b00, 16'h1388, 16'h0000, 16'h03E8);
    run_cmd(2'b11, 16'h1388, 16'h0000, 16'h01F4);
    wr(OFS_CTRL_MODE, 16'h0000);
    run_cmd(2'b01, 16'h1388, 16'h0000, 16'h03E8);
    report_and_stop();
  end
endmodule : tb_top
